// ===== core/tdm_switch_config_command_decoder.sv
// command decoder: connection and first configuration command registers
// ---------------------------------------------------------------------
// Operation
// - 8-bit config register, resets zero, 0000 nop
// - code 1000 clears all connections
// - code 1001 bidirectional connect, bit0 delay
// - code 1010 bit0 enables memory dump
// - code 0001 bit0 sets slave or master
// - code 0010 selects primary PLL reference
// - code 0011 secondary reference, 1111 special programming
// - code 0100 selects slave-path PLL source
// - code 0101 drives bus clock pairs
// - code 0110 frame clock frequency and direction
// - code 0111 enables legacy clock outputs
// - codes 1000/1001 configure network reference outputs
// - code 1010 fallback mode and switch-back
// - code 1011 local line rate per direction
// - code 1100 bus line rate, 11 all lines
// - code 1101 reads input or output slot
// - code 1110 stream switch establish or release
// - code 1111 applies bit shift to lines
// - shift fields: edge side, amount, half clock
// - general input bits 2..0 give frequency
// ---------------------------------------------------------------------
//
// The strobed register port was decided locally.
`default_nettype none
module tdm_switch_config_command_decoder #(
    parameter int LINES = 32
) (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // register port
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // device mode: 1 in H-mode, 0 in M-mode
    input wire logic h_mode,
    // operations to the switching core
    output cmd_decoder_pkg::conn_op_s conn_op,
    output cmd_decoder_pkg::cfg_s cfg,
    output logic [1:0] in_rate [LINES],
    output logic [1:0] out_rate [LINES],
    output logic [1:0] hbus_rate [LINES],
    output logic [4:0] in_shift [LINES],
    output logic [4:0] out_shift [LINES],
    output logic [1:0] stream_mode,
    output logic stream_pulse,
    output logic stream_est,
    output logic stream_rel_all,
    output logic slot_read_req,
    output logic slot_read_out,
    output logic special_cfg_start,
    output logic special_cfg_write,
    output logic [7:0] special_cfg_data
);
    // -----------------------------------------------------------------
    // register bank
    // -----------------------------------------------------------------
    logic [7:0] src_port_q, dst_port_q, out_slot_q, in_slot_q, gen_in1_q;
    cmd_decoder_pkg::cmd_s conn_cmd_q, cfg_cmd_q;
    logic [2:0] busy_q;
    logic h_mode_s1_q, h_mode_q;
    logic ready;
    logic wr_conn, wr_cfg;
    cmd_decoder_pkg::cmd_s wcmd;

    function automatic logic [4:0] line_of(input logic [7:0] port);
        line_of = port[4:0];
    endfunction : line_of

    assign ready = (busy_q == 3'h0);
    assign wcmd = cmd_decoder_pkg::cmd_s'(reg_wdata);
    assign wr_conn = reg_wr && reg_addr == cmd_decoder_pkg::ADDR_CONN_CMD;
    assign wr_cfg = reg_wr && reg_addr == cmd_decoder_pkg::ADDR_CFG_CONFIG_COMMAND_ONE;

    // mode strap is asynchronous to this clock
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            h_mode_s1_q <= 1'b0;
            h_mode_q <= 1'b0;
        end else begin
            h_mode_s1_q <= h_mode;
            h_mode_q <= h_mode_s1_q;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            src_port_q <= cmd_decoder_pkg::RESET_VAL;
            dst_port_q <= cmd_decoder_pkg::RESET_VAL;
            out_slot_q <= cmd_decoder_pkg::RESET_VAL;
            in_slot_q <= cmd_decoder_pkg::RESET_VAL;
            gen_in1_q <= cmd_decoder_pkg::RESET_VAL;
            conn_cmd_q <= cmd_decoder_pkg::cmd_s'(cmd_decoder_pkg::RESET_VAL);
            cfg_cmd_q <= cmd_decoder_pkg::cmd_s'(cmd_decoder_pkg::RESET_VAL);
        end else if (reg_wr) begin
            unique case (reg_addr)
                cmd_decoder_pkg::ADDR_SRC_PORT: src_port_q <= reg_wdata;
                cmd_decoder_pkg::ADDR_DST_PORT: dst_port_q <= reg_wdata;
                cmd_decoder_pkg::ADDR_OUT_SLOT: out_slot_q <= reg_wdata;
                cmd_decoder_pkg::ADDR_IN_SLOT: in_slot_q <= reg_wdata;
                cmd_decoder_pkg::ADDR_GEN_IN1: gen_in1_q <= reg_wdata;
                // writes while busy are dropped; host must poll ready
                cmd_decoder_pkg::ADDR_CONN_CMD: if (ready) conn_cmd_q <= wcmd;
                cmd_decoder_pkg::ADDR_CFG_CONFIG_COMMAND_ONE: cfg_cmd_q <= wcmd;
                default: ;
            endcase
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            reg_rdata <= 8'h00;
        end else if (reg_rd) begin
            unique case (reg_addr)
                cmd_decoder_pkg::ADDR_SRC_PORT: reg_rdata <= src_port_q;
                cmd_decoder_pkg::ADDR_DST_PORT: reg_rdata <= dst_port_q;
                cmd_decoder_pkg::ADDR_OUT_SLOT: reg_rdata <= out_slot_q;
                cmd_decoder_pkg::ADDR_IN_SLOT: reg_rdata <= in_slot_q;
                cmd_decoder_pkg::ADDR_GEN_IN1: reg_rdata <= gen_in1_q;
                cmd_decoder_pkg::ADDR_CONN_CMD: reg_rdata <= conn_cmd_q;
                cmd_decoder_pkg::ADDR_CFG_CONFIG_COMMAND_ONE: reg_rdata <= cfg_cmd_q;
                cmd_decoder_pkg::ADDR_STATUS:
                    reg_rdata <= {6'h00, h_mode_q, ready};
                default: reg_rdata <= 8'h00;
            endcase
        end else begin
            reg_rdata <= 8'h00;
        end
    end

    // -----------------------------------------------------------------
    // connection commands
    // -----------------------------------------------------------------
    // busy window models the core accepting the command
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            busy_q <= 3'h0;
            conn_op <= '0;
        end else begin
            conn_op.valid <= 1'b0;
            if (busy_q != 3'h0)
                busy_q <= busy_q - 3'h1;
            if (wr_conn && ready && wcmd.code != cmd_decoder_pkg::CC_NOP) begin
                busy_q <= 3'(cmd_decoder_pkg::BUSY_CYCLES);
                conn_op.valid <= 1'b1;
                conn_op.code <= wcmd.code;
                conn_op.qualifier <= wcmd.qualifier;
                conn_op.src_port <= src_port_q;
                conn_op.src_slot <= in_slot_q;
                conn_op.dst_port <= dst_port_q;
                conn_op.dst_slot <= out_slot_q;
            end
        end
    end

    // -----------------------------------------------------------------
    // configuration commands
    // -----------------------------------------------------------------
    logic [3:0] q;
    logic h_ok;
    assign q = wcmd.qualifier;
    assign h_ok = h_mode_q;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            cfg <= '0;
        end else begin
            if (wr_conn && ready && wcmd.code == cmd_decoder_pkg::CC_DUMP)
                cfg.dump_en <= q[0];
            if (wr_cfg) begin
                unique case (wcmd.code)
                    cmd_decoder_pkg::CF_ROLE: if (h_ok) cfg.master <= q[0];
                    cmd_decoder_pkg::CF_PRIMARY: begin
                        // unused codes and wrong-mode sources are ignored
                        if (q != 4'h9 && q != 4'ha &&
                            !((q == 4'h1 || q == 4'h2) && h_ok) &&
                            !((q == 4'h3 || q == 4'h4 || q > 4'h6) && !h_ok)) begin
                            cfg.primary_ref <= q;
                            cfg.primary_freq <= gen_in1_q[2:0];
                        end
                    end
                    cmd_decoder_pkg::CF_SECOND: begin
                        if (h_ok && q != cmd_decoder_pkg::Q_SPECIAL) begin
                            cfg.secondary_ref <= q;
                            cfg.secondary_freq <= gen_in1_q[2:0];
                        end
                    end
                    cmd_decoder_pkg::CF_SLAVE_SRC:
                        if (h_ok && q >= 4'h5 && q <= 4'hc) cfg.slave_src <= q;
                    cmd_decoder_pkg::CF_CT_CLK:
                        if (h_ok && q[1:0] != 2'h3) cfg.ct_clk_out <= q[1:0];
                    cmd_decoder_pkg::CF_PCM_CLK: begin
                        if (q[2:0] != 3'h0 && q[2:0] <= 3'h4) begin
                            cfg.pcm_freq <= q[2:0];
                            cfg.pcm_output <= q[3];
                        end
                    end
                    cmd_decoder_pkg::CF_COMPAT: begin
                        if (h_ok) begin
                            cfg.legacy_en <= q[1:0];
                            cfg.third_bus <= q[3:2];
                        end
                    end
                    cmd_decoder_pkg::CF_NETREF1:
                        if (h_ok && q[3:1] <= 3'h4) cfg.netref1 <= q;
                    cmd_decoder_pkg::CF_NETREF2:
                        if (h_ok && q[3:1] <= 3'h4) cfg.netref2 <= q;
                    // bit 3 phase alignment stored as written
                    cmd_decoder_pkg::CF_FALLBACK: if (h_ok) cfg.fallback <= q;
                    default: ;
                endcase
            end
        end
    end

    // -----------------------------------------------------------------
    // per-line rate and shift tables
    // -----------------------------------------------------------------
    logic [4:0] shift_val;
    assign shift_val = gen_in1_q[4:0];

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            for (int i = 0; i < LINES; i++) begin
                in_rate[i] <= 2'h0;
                out_rate[i] <= 2'h0;
                hbus_rate[i] <= 2'h0;
                in_shift[i] <= 5'h00;
                out_shift[i] <= 5'h00;
            end
        end else if (wr_cfg) begin
            unique case (wcmd.code)
                cmd_decoder_pkg::CF_LOCAL_RATE: begin
                    if (q[2]) in_rate[line_of(src_port_q)] <= q[1:0];
                    if (q[3]) out_rate[line_of(dst_port_q)] <= q[1:0];
                end
                cmd_decoder_pkg::CF_HBUS_RATE: begin
                    if (h_ok) begin
                        if (q[1:0] == 2'h3) begin
                            for (int i = 0; i < LINES; i++)
                                hbus_rate[i] <= 2'h2;
                        end else begin
                            hbus_rate[line_of(src_port_q)] <= q[1:0];
                        end
                    end
                end
                cmd_decoder_pkg::CF_BIT_SHIFT: begin
                    unique case (q[1:0])
                        2'h0: in_shift[line_of(src_port_q)] <= shift_val;
                        2'h1: for (int i = 0; i < LINES; i++) in_shift[i] <= shift_val;
                        2'h2: for (int i = 0; i < LINES; i++) out_shift[i] <= shift_val;
                        2'h3: begin
                            for (int i = 0; i < LINES; i++) begin
                                in_shift[i] <= shift_val;
                                out_shift[i] <= shift_val;
                            end
                        end
                    endcase
                end
                default: ;
            endcase
        end
    end

    // -----------------------------------------------------------------
    // one-cycle strobes to the core, with held mode and data fields
    // -----------------------------------------------------------------
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            stream_pulse <= 1'b0;
            stream_mode <= 2'h0;
            stream_est <= 1'b0;
            stream_rel_all <= 1'b0;
            slot_read_req <= 1'b0;
            slot_read_out <= 1'b0;
            special_cfg_start <= 1'b0;
            special_cfg_write <= 1'b0;
            special_cfg_data <= 8'h00;
        end else begin
            stream_pulse <= 1'b0;
            slot_read_req <= 1'b0;
            special_cfg_start <= 1'b0;
            special_cfg_write <= 1'b0;
            stream_rel_all <= 1'b0;
            if (wr_cfg) begin
                unique case (wcmd.code)
                    cmd_decoder_pkg::CF_STREAM: begin
                        // equal ports are the host's fault; ignored as a guard
                        if (h_ok && src_port_q != dst_port_q) begin
                            stream_pulse <= 1'b1;
                            stream_mode <= q[1:0];
                            stream_est <= q[2];
                            stream_rel_all <= q[3];
                        end
                    end
                    cmd_decoder_pkg::CF_READ_SLOT: begin
                        slot_read_req <= 1'b1;
                        slot_read_out <= q[0];
                    end
                    cmd_decoder_pkg::CF_SECOND:
                        special_cfg_start <= h_ok && q == cmd_decoder_pkg::Q_SPECIAL;
                    cmd_decoder_pkg::CF_SLAVE_SRC: begin
                        if (h_ok && q == cmd_decoder_pkg::Q_SPECIAL) begin
                            special_cfg_write <= 1'b1;
                            special_cfg_data <= gen_in1_q;
                        end
                    end
                    default: ;
                endcase
            end
        end
    end
endmodule : tdm_switch_config_command_decoder
`default_nettype wire

// ===== core/cmd_decoder_pkg.sv
// package: register map, field layout and codes for the command decoder
`default_nettype none
package cmd_decoder_pkg;
    localparam logic [7:0] ADDR_SRC_PORT = 8'h01;
    localparam logic [7:0] ADDR_DST_PORT = 8'h02;
    localparam logic [7:0] ADDR_OUT_SLOT = 8'h03;
    localparam logic [7:0] ADDR_GEN_IN1 = 8'h04;
    localparam logic [7:0] ADDR_CONN_CMD = 8'h06;
    localparam logic [7:0] ADDR_CFG_CONFIG_COMMAND_ONE = 8'h08;
    localparam logic [7:0] ADDR_IN_SLOT = 8'h09;
    localparam logic [7:0] ADDR_STATUS = 8'h0f;
    localparam logic [7:0] RESET_VAL = 8'h00;
    localparam int CODE_LSB = 0;
    localparam int QUAL_LSB = 4;
    localparam int RDY_BIT = 0;
    localparam int HMODE_BIT = 1;
    localparam int BUSY_CYCLES = 4;
    localparam logic [3:0] CC_NOP = 4'h0;
    localparam logic [3:0] CC_DISC_ALL = 4'h8;
    localparam logic [3:0] CC_BIDIR = 4'h9;
    localparam logic [3:0] CC_DUMP = 4'ha;
    localparam logic [3:0] CF_ROLE = 4'h1;
    localparam logic [3:0] CF_PRIMARY = 4'h2;
    localparam logic [3:0] CF_SECOND = 4'h3;
    localparam logic [3:0] CF_SLAVE_SRC = 4'h4;
    localparam logic [3:0] CF_CT_CLK = 4'h5;
    localparam logic [3:0] CF_PCM_CLK = 4'h6;
    localparam logic [3:0] CF_COMPAT = 4'h7;
    localparam logic [3:0] CF_NETREF1 = 4'h8;
    localparam logic [3:0] CF_NETREF2 = 4'h9;
    localparam logic [3:0] CF_FALLBACK = 4'ha;
    localparam logic [3:0] CF_LOCAL_RATE = 4'hb;
    localparam logic [3:0] CF_HBUS_RATE = 4'hc;
    localparam logic [3:0] CF_READ_SLOT = 4'hd;
    localparam logic [3:0] CF_STREAM = 4'he;
    localparam logic [3:0] CF_BIT_SHIFT = 4'hf;
    localparam logic [3:0] Q_SPECIAL = 4'hf;

    typedef struct packed {
        logic [3:0] qualifier;
        logic [3:0] code;
    } cmd_s;

    typedef struct packed {
        logic valid;
        logic [3:0] code;
        logic [3:0] qualifier;
        logic [7:0] src_port;
        logic [7:0] src_slot;
        logic [7:0] dst_port;
        logic [7:0] dst_slot;
    } conn_op_s;

    typedef struct packed {
        logic master;
        logic [3:0] primary_ref;
        logic [2:0] primary_freq;
        logic [3:0] secondary_ref;
        logic [2:0] secondary_freq;
        logic [3:0] slave_src;
        logic [1:0] ct_clk_out;
        logic [2:0] pcm_freq;
        logic pcm_output;
        logic [1:0] legacy_en;
        logic [1:0] third_bus;
        logic [3:0] netref1;
        logic [3:0] netref2;
        logic [3:0] fallback;
        logic dump_en;
    } cfg_s;
endpackage : cmd_decoder_pkg
`default_nettype wire

// ===== tb/tdm_switch_config_command_decoder_assertions.sv
// checker: port-level assertions for the command decoder
`default_nettype none
module cmd_decoder_checker (
    // clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // register port and mode
    input wire logic [7:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [7:0] reg_rdata,
    input wire logic h_mode,
    // decoded outputs
    input wire cmd_decoder_pkg::conn_op_s conn_op,
    input wire cmd_decoder_pkg::cfg_s cfg,
    input wire logic stream_pulse,
    input wire logic stream_rel_all,
    input wire logic slot_read_req,
    input wire logic slot_read_out,
    input wire logic special_cfg_start,
    input wire logic special_cfg_write
);
    default clocking @(posedge clk_sys); endclocking
    default disable iff (!rst_n);
    // ------------------------
    // helpers
    // ------------------------
    logic [2:0] h_hist_q;
    logic cfg_wr, conn_wr, h_ok;
    // mode passes two flops, so only a long-settled mode is trusted
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            h_hist_q <= 3'h0;
        end else begin
            h_hist_q <= {h_hist_q[1:0], h_mode};
        end
    end
    assign h_ok = h_mode && (&h_hist_q);
    assign cfg_wr = reg_wr && reg_addr == cmd_decoder_pkg::ADDR_CFG_CONFIG_COMMAND_ONE;
    assign conn_wr = reg_wr && reg_addr == cmd_decoder_pkg::ADDR_CONN_CMD;
    sequence quiet4;
        !conn_op.valid [*4];
    endsequence
    chk_rdata_idle: assert property (!reg_rd |=> reg_rdata == 8'h00)
        else $error("read data not zero");
    chk_cfg_holds: assert property (!(cfg_wr || conn_wr) |=> $stable(cfg))
        else $error("config changed unprompted");
    chk_conn_cause: assert property (conn_op.valid |-> $past(conn_wr))
        else $error("connection op unprompted");
    chk_conn_fields: assert property (conn_op.valid |->
        conn_op.code == $past(reg_wdata[3:0]) && conn_op.qualifier == $past(reg_wdata[7:4]))
        else $error("connection op fields wrong");
    chk_busy_refused: assert property (conn_op.valid |=> quiet4)
        else $error("command taken while busy");
    chk_master_bit: assert property (cfg_wr && h_ok &&
        reg_wdata[3:0] == cmd_decoder_pkg::CF_ROLE |=> cfg.master == $past(reg_wdata[4]))
        else $error("role bit wrong");
    chk_special_start: assert property (cfg_wr && h_ok && reg_wdata == 8'hf3
        |=> special_cfg_start)
        else $error("special start missing");
    chk_special_write: assert property (cfg_wr && h_ok && reg_wdata == 8'hf4
        |=> special_cfg_write)
        else $error("special write missing");
    chk_slot_read: assert property (cfg_wr &&
        reg_wdata[3:0] == cmd_decoder_pkg::CF_READ_SLOT
        |=> slot_read_req && slot_read_out == $past(reg_wdata[4]))
        else $error("slot read wrong");
    chk_release_all: assert property (stream_pulse || stream_rel_all |-> stream_pulse
        && stream_rel_all == $past(reg_wdata[7])
        && $past(cfg_wr && reg_wdata[3:0] == cmd_decoder_pkg::CF_STREAM))
        else $error("stream strobe unprompted");
endmodule : cmd_decoder_checker
bind tdm_switch_config_command_decoder cmd_decoder_checker i_cmd_decoder_checker (.clk_sys,
    .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .h_mode, .conn_op, .cfg,
    .stream_pulse, .stream_rel_all, .slot_read_req, .slot_read_out, .special_cfg_start,
    .special_cfg_write);
`default_nettype wire

// ===== tb/host_model.sv
// host model: register port master for the command decoder
`default_nettype none
module host_model (
    // clock
    input wire logic clk_sys,
    // register port
    output logic [7:0] reg_addr,
    output logic [7:0] reg_wdata,
    output logic reg_wr,
    output logic reg_rd,
    input wire logic [7:0] reg_rdata
);
    timeunit 1ns;
    timeprecision 1ps;
    initial begin
        reg_wr = 1'b0;
        reg_rd = 1'b0;
    end
    // released lines show the inverse so no stale value can pass
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        reg_addr <= ~a;
        reg_wdata <= ~d;
        @(posedge clk_sys);
    endtask : wr
    task automatic rd(input logic [7:0] a, output logic [7:0] d);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        reg_addr <= ~a;
        #1 d = reg_rdata;
        @(posedge clk_sys);
    endtask : rd
    task automatic conn(input logic [7:0] d);
        logic [7:0] s;
        s = 8'h00;
        for (int i = 0; i < 16 && s[cmd_decoder_pkg::RDY_BIT] !== 1'b1; i++) begin
            rd(cmd_decoder_pkg::ADDR_STATUS, s);
        end
        wr(cmd_decoder_pkg::ADDR_CONN_CMD, d);
    endtask : conn
endmodule : host_model
`default_nettype wire

// ===== tb/tdm_switch_config_command_decoder_bench.sv
// bench: directed scenarios for the command decoder
`default_nettype none
module tdm_switch_config_command_decoder_bench;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {
        logic [7:0] gi;
        logic [7:0] wd;
        logic [7:0] exp;
    } step_s;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic h_mode = 1'b1;
    logic [7:0] reg_addr, reg_wdata, reg_rdata, special_cfg_data, rv;
    logic reg_wr, reg_rd, stream_pulse, stream_est, stream_rel_all;
    logic slot_read_req, slot_read_out, special_cfg_start, special_cfg_write;
    logic [1:0] stream_mode;
    logic [1:0] in_rate [32], out_rate [32], hbus_rate [32];
    logic [4:0] in_shift [32], out_shift [32];
    cmd_decoder_pkg::conn_op_s conn_op;
    cmd_decoder_pkg::cfg_s cfg;
    int failures = 0;
    int check_count = 0;
    int cycles = 0;
    // primary and fallback go before the role command
    step_s steps [17] = '{
        '{8'h04, 8'h52, 8'h45}, '{8'h04, 8'h92, 8'h45}, '{8'h04, 8'h12, 8'h45},
        '{8'h06, 8'h33, 8'h63}, '{8'h06, 8'hf3, 8'h63},
        '{8'h00, 8'h54, 8'h05}, '{8'h00, 8'h24, 8'h05}, '{8'h5a, 8'hf4, 8'h05},
        '{8'h00, 8'h25, 8'h02}, '{8'h00, 8'hb6, 8'h0b}, '{8'h00, 8'h06, 8'h0b},
        '{8'h00, 8'hb7, 8'h0b}, '{8'h00, 8'h38, 8'h03}, '{8'h00, 8'h99, 8'h09},
        '{8'h00, 8'hda, 8'h0d}, '{8'h00, 8'h11, 8'h01}, '{8'h00, 8'h01, 8'h00}
    };
    tdm_switch_config_command_decoder #(.LINES(32)) i_tdm_switch_config_command_decoder (
        .clk_sys, .rst_n, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .h_mode,
        .conn_op, .cfg, .in_rate, .out_rate, .hbus_rate, .in_shift, .out_shift, .stream_mode,
        .stream_pulse, .stream_est, .stream_rel_all, .slot_read_req, .slot_read_out,
        .special_cfg_start, .special_cfg_write, .special_cfg_data);
    host_model i_host_model (.clk_sys, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata);
    always #5 clk_sys = ~clk_sys;
    always @(posedge clk_sys) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            failures++;
            conclude();
        end
    end
    // ------------------------
    // helpers
    // ------------------------
    task automatic conclude();
        $display("checks %0d failures %0d", check_count, failures);
        if (failures == 0 && check_count > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : conclude
    task automatic check(input string name, input logic [7:0] seen, input logic [7:0] exp);
        check_count++;
        if (seen !== exp) begin
            failures++;
            $display("ERROR %s expected %h seen %h", name, exp, seen);
        end
    endtask : check
    task automatic cw(input logic [7:0] d);
        i_host_model.wr(cmd_decoder_pkg::ADDR_CFG_CONFIG_COMMAND_ONE, d);
    endtask : cw
    task automatic gw(input logic [7:0] d);
        i_host_model.wr(cmd_decoder_pkg::ADDR_GEN_IN1, d);
    endtask : gw
    task automatic ports(input logic [7:0] s, input logic [7:0] d);
        i_host_model.wr(cmd_decoder_pkg::ADDR_SRC_PORT, s);
        i_host_model.wr(cmd_decoder_pkg::ADDR_DST_PORT, d);
    endtask : ports
    function automatic logic [7:0] field(input logic [3:0] c);
        case (c)
            cmd_decoder_pkg::CF_ROLE: return {7'h00, cfg.master};
            cmd_decoder_pkg::CF_PRIMARY: return {1'b0, cfg.primary_freq, cfg.primary_ref};
            cmd_decoder_pkg::CF_SECOND: return {1'b0, cfg.secondary_freq, cfg.secondary_ref};
            cmd_decoder_pkg::CF_SLAVE_SRC: return {4'h0, cfg.slave_src};
            cmd_decoder_pkg::CF_CT_CLK: return {6'h00, cfg.ct_clk_out};
            cmd_decoder_pkg::CF_PCM_CLK: return {4'h0, cfg.pcm_output, cfg.pcm_freq};
            cmd_decoder_pkg::CF_COMPAT: return {4'h0, cfg.third_bus, cfg.legacy_en};
            cmd_decoder_pkg::CF_NETREF1: return {4'h0, cfg.netref1};
            cmd_decoder_pkg::CF_NETREF2: return {4'h0, cfg.netref2};
            default: return {4'h0, cfg.fallback};
        endcase
    endfunction : field
    // ------------------------
    // scenarios
    // ------------------------
    task automatic t_reset();
        i_host_model.rd(cmd_decoder_pkg::ADDR_CFG_CONFIG_COMMAND_ONE, rv);
        check("cfg reg reset", rv, cmd_decoder_pkg::RESET_VAL);
        i_host_model.rd(8'h3c, rv);
        check("unmapped read", rv, 8'h00);
        check("cfg reset", 8'(|cfg), 8'h00);
    endtask : t_reset
    task automatic t_config();
        foreach (steps[i]) begin
            gw(steps[i].gi);
            cw(steps[i].wd);
            check("cfg field", field(steps[i].wd[3:0]), steps[i].exp);
        end
        check("special data", special_cfg_data, 8'h5a);
        i_host_model.rd(cmd_decoder_pkg::ADDR_CFG_CONFIG_COMMAND_ONE, rv);
        check("cfg readback", rv, 8'h01);
    endtask : t_config
    task automatic t_mode();
        h_mode <= 1'b0;
        repeat (3) @(posedge clk_sys);
        cw(8'h15);
        check("h-only in m-mode", field(cmd_decoder_pkg::CF_CT_CLK), 8'h02);
        gw(8'h04);
        cw(8'h12);
        check("m-only primary", field(cmd_decoder_pkg::CF_PRIMARY), 8'h41);
        h_mode <= 1'b1;
        repeat (3) @(posedge clk_sys);
    endtask : t_mode
    task automatic t_conn();
        ports(8'h03, 8'h05);
        i_host_model.wr(cmd_decoder_pkg::ADDR_IN_SLOT, 8'h11);
        i_host_model.wr(cmd_decoder_pkg::ADDR_OUT_SLOT, 8'h22);
        i_host_model.conn(8'h19);
        check("bidir cmd", {conn_op.qualifier, conn_op.code}, 8'h19);
        check("bidir slots", conn_op.src_slot ^ conn_op.dst_slot, 8'h33);
        i_host_model.rd(cmd_decoder_pkg::ADDR_STATUS, rv);
        check("busy after cmd", 8'(rv[cmd_decoder_pkg::RDY_BIT]), 8'h00);
        i_host_model.conn(8'h08);
        check("disconnect all", 8'(conn_op.code), 8'h08);
        i_host_model.conn(8'h1a);
        check("dump on", 8'(cfg.dump_en), 8'h01);
        i_host_model.conn(8'h0a);
        check("dump off", 8'(cfg.dump_en), 8'h00);
    endtask : t_conn
    task automatic t_rates();
        cw(8'heb);
        check("in rate", 8'({in_rate[3], in_rate[4], out_rate[5]}), 8'h22);
        cw(8'h1c);
        check("hbus rate", 8'(hbus_rate[3]), 8'h01);
        cw(8'h3c);
        check("hbus all", 8'({hbus_rate[0], hbus_rate[31]}), 8'h0a);
    endtask : t_rates
    task automatic t_shift();
        gw(8'h1b);
        cw(8'h0f);
        check("shift one input", 8'(in_shift[3]), 8'h1b);
        gw(8'h0e);
        cw(8'h2f);
        check("shift outputs", 8'(out_shift[0] ^ out_shift[31]), 8'h00);
        check("shift out value", 8'(out_shift[31]), 8'h0e);
        check("input untouched", 8'(in_shift[3]), 8'h1b);
        cw(8'h1f);
        check("shift all inputs", 8'(in_shift[7]), 8'h0e);
    endtask : t_shift
    task automatic t_stream();
        ports(8'h03, 8'h05);
        cw(8'h6e);
        check("stream est", {5'h00, stream_est, stream_mode}, 8'h06);
        ports(8'h03, 8'h03);
        cw(8'h1e);
        check("equal ports ignored", {5'h00, stream_est, stream_mode}, 8'h06);
        ports(8'h03, 8'h05);
        cw(8'h8e);
        cw(8'h0d);
        cw(8'h1d);
        check("slot read output", 8'(slot_read_out), 8'h01);
    endtask : t_stream
    initial begin
        repeat (5) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        t_reset();
        t_config();
        t_mode();
        t_conn();
        t_rates();
        t_shift();
        t_stream();
        conclude();
    end
endmodule : tdm_switch_config_command_decoder_bench
`default_nettype wire
